// [include/uv_pkg.sv]
`default_nettype none
package uv_pkg;
  // status register, printed offset is not a multiple of four: kept as index
  localparam logic [15:0] STATUS_IDX = 16'hfe0f;
  localparam logic [17:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
  localparam logic [17:0] CONFIG_ADDR = 18'h00010;
  localparam logic [17:0] IRQ_STAT_ADDR = 18'h00014;
  localparam logic [17:0] IRQ_MASK_ADDR = 18'h00018;
  localparam int FLAG_BIT = 7;
  localparam int CFG_PWR_BIT = 0;
  localparam int CFG_RST_BIT = 1;
  localparam int CFG_STOP_BIT = 2;
  localparam logic [2:0] CONFIG_RESET = 3'h1;
  localparam int FILTER_CYCLES = 9;
  localparam int FLAG_MIN_XTAL = 32;
  localparam int FLAG_MAX_XTAL = 40;
  localparam int FLAG_XTAL = 36;
  localparam int XTAL_DIV = 4;
  localparam int EV_TRIP_BIT = 0;
  localparam int EV_FLAG_BIT = 1;
  localparam int EV_REL_BIT = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic below_fall;
    logic above_rise;
  } comp_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_HOLD = 2'b10
  } mon_state_t;
endpackage : uv_pkg
`default_nettype wire

// [design/undervoltage_reset_filter.sv]
// Contract
// - monitor is active straight out of reset, no software needed
// - comparator is observed only while monitor power enable is set; a held reset still releases on recovery with it clear
// - with reset enable, nine consecutive low cpu cycles assert reset
// - reset holds until supply rises above the recovery level
// - one cycle above recovery level releases reset
// - flag follows the comparator, not the reset enable
// - active-low external reset pin is driven low during reset
// - flag sets after 32 to 40 crystal cycles low, clears above recovery
// - flag read-only, writes ignored, cleared by reset
// - the monitor itself raises no interrupt request
// - monitoring continues unchanged in wait mode
// - undervoltage reset can end wait mode
// - with stop enable and power enable, monitor stays active in stop
// - in stop mode a trip bypasses the filter and resets directly
// - without stop enable, monitor goes inactive in stop mode
//
// Our own choice: the AXI4-Lite slave port.
`default_nettype none
module undervoltage_reset_filter #(
  parameter int FILTER = uv_pkg::FILTER_CYCLES,
  parameter int XTAL_FLAG = uv_pkg::FLAG_XTAL,
  parameter int DIV = uv_pkg::XTAL_DIV
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire uv_pkg::comp_t comp, // supply comparator outputs
  input wire logic wait_mode, // cpu in wait
  input wire logic stop_mode, // cpu in stop, cpu clock absent
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic uv_reset, // system reset request, active high
  output logic ext_reset_n, // external reset pin drive, active low
  output logic ext_reset_oe, // external reset pin output enable
  output logic irq // wrapper interrupt, level
);
  import uv_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // register map, one word per register, byte addresses
  //   status : bit 7 is the undervolt flag, every other bit reads zero
  //   config : bit 0 power enable, bit 1 reset enable, bit 2 stop enable
  //   events : bit 0 trip, bit 1 flag set, bit 2 reset released, write one clears
  //   mask   : same layout as events; irq is high while a masked-in event is set
  // status sits at four times its printed index, so high address bits matter;
  // only the low 18 address bits are decoded, anything above them aliases
  // writes to status are answered okay and change nothing
  // unmapped reads and writes answer slverr, reads then carry zero
  //
  // timing, all counted in aclk cycles
  //   write   : address and data taken in either order, response two cycles after both
  //   read    : data one cycle after the address is taken, held until rready
  //   filter  : nine low samples in a row, reset flop set on the ninth
  //   release : first sample above recovery drops reset on the next edge
  //   flag    : crystal tick every DIV cycles, flag after XTAL_FLAG ticks low
  //
  // hazards worth knowing
  //   filter and flag counter only run while the monitor is active,
  //   so clearing power enable freezes the flag at its last value
  //   in stop mode there is no cpu clock to filter with, so the first low
  //   sample trips; supply noise in stop can therefore reset the part
  //   release ignores the enables: a held reset always ends once the supply
  //   recovers, even if software switched the monitor off meanwhile
  //   the config register stands in for option bits kept outside this block,
  //   so software may change it at any time, also while a reset is held
  //   wait mode is only an input for observation: monitoring never pauses
  //   the interrupt belongs to the register wrapper, not to the monitor
  //
  // trade-offs
  //   the flag threshold is one fixed tick count inside the allowed window,
  //   which costs a little latency against the earliest legal setting
  //   ready signals are stored in flops so no port depends on logic after a flop

  ////////////////////////////////////////////////////////////////////////
  // parameter checks refuse sizes the 8-bit counters cannot hold
  if (FILTER < 1 || FILTER > 255) begin : g_bad_filter
    $error("FILTER out of range");
  end
  if (XTAL_FLAG < FLAG_MIN_XTAL || XTAL_FLAG > FLAG_MAX_XTAL) begin : g_bad_xtal
    $error("XTAL_FLAG out of window");
  end
  if (DIV < 1 || DIV > 255) begin : g_bad_div
    $error("DIV out of range");
  end

  localparam logic [7:0] FILT_LAST = 8'(FILTER - 1);
  localparam logic [7:0] XFLAG = 8'(XTAL_FLAG);
  localparam logic [7:0] DIV_LAST = 8'(DIV - 1);
  localparam int LOW_LANE = 0;

  typedef struct packed {
    mon_state_t st;
    logic [7:0] filt;
    logic [7:0] div;
    logic [7:0] xlow;
    logic flag;
    logic [2:0] cfg;
    logic [2:0] ev;
    logic [2:0] mask;
    logic aw_got;
    logic w_got;
    logic [17:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic rst_out;
    logic irq;
    logic aw_rdy; // write address ready flop
    logic w_rdy; // write data ready flop
    logic ar_rdy; // read address ready flop
    logic rst_n; // pin drive value
    logic rst_oe; // pin drive enable
  } state_t;

  state_t s_reg, s_next;

  function automatic logic hit(input logic [17:0] a, input logic [17:0] r);
    hit = (a == r);
  endfunction : hit

  function automatic logic mapped(input logic [17:0] a);
    mapped = hit(a, STATUS_ADDR) || hit(a, CONFIG_ADDR) ||
             hit(a, IRQ_STAT_ADDR) || hit(a, IRQ_MASK_ADDR);
  endfunction : mapped

  function automatic logic [31:0] rd_word(input state_t s, input logic [17:0] a);
    rd_word = 32'h0;
    if (hit(a, STATUS_ADDR)) begin
      // reserved bits read zero
      rd_word[FLAG_BIT] = s.flag;
    end else if (hit(a, CONFIG_ADDR)) begin
      rd_word[CFG_STOP_BIT:CFG_PWR_BIT] = s.cfg;
    end else if (hit(a, IRQ_STAT_ADDR)) begin
      rd_word[EV_REL_BIT:EV_TRIP_BIT] = s.ev;
    end else if (hit(a, IRQ_MASK_ADDR)) begin
      rd_word[EV_REL_BIT:EV_TRIP_BIT] = s.mask;
    end
  endfunction : rd_word

  logic active; // monitor observes the comparator
  logic pwr; // power enable
  logic rst_en; // reset enable
  logic stop_en; // stop enable
  logic xtick; // crystal clock enable pulse
  logic trip; // reset entered this cycle
  logic fire; // filter satisfied this cycle
  logic flag_set; // flag rises this cycle
  logic w_do; // write lands this cycle
  logic [2:0] ev_new;
  logic [17:0] ra;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_next = s_reg;
    pwr = s_reg.cfg[CFG_PWR_BIT];
    rst_en = s_reg.cfg[CFG_RST_BIT];
    stop_en = s_reg.cfg[CFG_STOP_BIT];
    // active from reset since power enable resets to one
    active = pwr && (!stop_mode || stop_en);
    xtick = (s_reg.div == DIV_LAST);
    trip = 1'b0;
    flag_set = 1'b0;
    ev_new = 3'h0;
    ra = s_axi_araddr[17:0];

    // crystal clock is a divided enable from aclk
    s_next.div = xtick ? 8'h0 : s_reg.div + 8'h1;

    // flag tracks the comparator, independent of reset enable
    if (active) begin
      if (comp.above_rise) begin
        s_next.flag = 1'b0;
        s_next.xlow = 8'h0;
      end else if (comp.below_fall) begin
        // saturates at the threshold, so a long low never wraps
        if (xtick && s_reg.xlow < XFLAG) begin
          s_next.xlow = s_reg.xlow + 8'h1;
        end
        if (s_reg.xlow >= XFLAG && !s_reg.flag) begin
          s_next.flag = 1'b1;
          flag_set = 1'b1;
        end
      end else begin
        s_next.xlow = 8'h0; // between levels flag keeps value
      end
    end

    // filter counts cpu cycles; stop mode has no cpu clock, so bypass it
    fire = 1'b0;
    case (s_reg.st)
      ST_RUN: begin
        if (active && comp.below_fall) begin
          if (stop_mode) begin
            fire = 1'b1;
          end else if (s_reg.filt >= FILT_LAST) begin
            fire = 1'b1;
          end else begin
            s_next.filt = s_reg.filt + 8'h1;
          end
        end else begin
          s_next.filt = 8'h0;
        end
        // wait mode does not block the reset
        if (fire && rst_en) begin
          s_next.st = ST_HOLD;
          s_next.rst_out = 1'b1;
          s_next.filt = 8'h0;
          trip = 1'b1;
        end else if (fire) begin
          s_next.filt = 8'h0;
        end
      end
      ST_HOLD: begin
        if (comp.above_rise) begin
          s_next.st = ST_RUN;
          s_next.rst_out = 1'b0;
          ev_new[EV_REL_BIT] = 1'b1;
        end
      end
      default: begin
        s_next.st = ST_RUN;
        s_next.rst_out = 1'b0;
      end
    endcase
    ev_new[EV_TRIP_BIT] = trip;
    ev_new[EV_FLAG_BIT] = flag_set;

    // axi write channel, address and data in either order
    if (s_axi_awvalid && !s_reg.aw_got) begin
      s_next.aw_got = 1'b1;
      s_next.awa = s_axi_awaddr[17:0];
    end
    if (s_axi_wvalid && !s_reg.w_got) begin
      s_next.w_got = 1'b1;
      s_next.wd = s_axi_wdata;
      s_next.ws = s_axi_wstrb;
    end
    w_do = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;
    if (w_do) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_OKAY;
      if (hit(s_reg.awa, CONFIG_ADDR)) begin
        if (s_reg.ws[LOW_LANE]) begin
          s_next.cfg = s_reg.wd[CFG_STOP_BIT:CFG_PWR_BIT];
        end
      end else if (hit(s_reg.awa, IRQ_STAT_ADDR)) begin
        if (s_reg.ws[LOW_LANE]) begin
          s_next.ev = s_reg.ev & ~s_reg.wd[EV_REL_BIT:EV_TRIP_BIT];
        end
      end else if (hit(s_reg.awa, IRQ_MASK_ADDR)) begin
        if (s_reg.ws[LOW_LANE]) begin
          s_next.mask = s_reg.wd[EV_REL_BIT:EV_TRIP_BIT];
        end
      end else if (hit(s_reg.awa, STATUS_ADDR)) begin
        s_next.bresp = RESP_OKAY;
      end else begin
        s_next.bresp = RESP_SLVERR;
      end
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end

    // set wins over a same-cycle clear
    s_next.ev = s_next.ev | ev_new;

    if (s_axi_arvalid && !s_reg.rvalid) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = rd_word(s_reg, ra);
      s_next.rresp = mapped(ra) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end

    // wrapper status interrupt only; the monitor itself asks for none
    s_next.irq = |(s_next.ev & s_next.mask);

    // every port leaves from its own flop, readies included
    s_next.aw_rdy = !s_next.aw_got;
    s_next.w_rdy = !s_next.w_got;
    s_next.ar_rdy = !s_next.rvalid;
    s_next.rst_n = !s_next.rst_out;
    s_next.rst_oe = s_next.rst_out;
  end

  ////////////////////////////////////////////////////////////////////////
  // reset leaves the monitor powered, so it watches from the first cycle;
  // readies and the pin value come up at their idle levels, not at zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.st <= ST_RUN;
      s_reg.cfg <= CONFIG_RESET;
      s_reg.flag <= 1'b0;
      s_reg.aw_rdy <= 1'b1;
      s_reg.w_rdy <= 1'b1;
      s_reg.ar_rdy <= 1'b1;
      s_reg.rst_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = s_reg.aw_rdy;
  assign s_axi_wready = s_reg.w_rdy;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.ar_rdy;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rresp = s_reg.rresp;
  assign s_axi_rdata = s_reg.rdata;
  assign uv_reset = s_reg.rst_out;
  assign ext_reset_n = s_reg.rst_n;
  assign ext_reset_oe = s_reg.rst_oe;
  assign irq = s_reg.irq;
endmodule : undervoltage_reset_filter
`default_nettype wire

// [verif/uv_props.sv]
`default_nettype none
module uv_chk (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset
  input wire uv_pkg::comp_t comp, // comparator
  input wire logic stop_mode, // stop
  input wire logic uv_reset, // reset out
  input wire logic ext_reset_n, // pin value
  input wire logic ext_reset_oe, // pin enable
  input wire logic irq, // interrupt
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready // r ready
);
  timeunit 1ns;
  timeprecision 1ps;
  import uv_pkg::*;
  logic [3:0] low_cnt_reg;
  // saturates so long lows never wrap back under nine
  always_ff @(posedge aclk) begin
    if (!aresetn || !comp.below_fall) begin
      low_cnt_reg <= 4'h0;
    end else if (low_cnt_reg != 4'hf) begin
      low_cnt_reg <= low_cnt_reg + 4'h1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////
  a_pin_follows: assert property (ext_reset_n == !uv_reset && ext_reset_oe == uv_reset)
    else $error("pin drive differs from reset");
  a_filter_nine: assert property ($rose(uv_reset) && !$past(stop_mode) |-> low_cnt_reg >= 4'h9)
    else $error("reset before nine low samples");
  a_trip_low: assert property ($rose(uv_reset) |-> $past(comp.below_fall))
    else $error("reset without low sample");
  a_hold_reset: assert property (uv_reset && !comp.above_rise |=> uv_reset)
    else $error("reset dropped early");
  a_one_release: assert property (comp.above_rise |=> !uv_reset)
    else $error("reset not released");
  a_reset_idle: assert property ($rose(aresetn) |-> !uv_reset && ext_reset_n && !irq)
    else $error("outputs not idle after reset");
  a_read_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  c_filter: cover property ($rose(uv_reset) && !$past(stop_mode));
  c_stop: cover property ($rose(uv_reset) && $past(stop_mode));
  c_release: cover property ($fell(uv_reset));
  c_irq: cover property ($rose(irq));
endmodule : uv_chk
`default_nettype wire

// [verif/uv_supply_model.sv]
`default_nettype none
module uv_supply_model (
  input wire logic [1:0] level, // 0 low, 1 between, 2 high
  output var uv_pkg::comp_t comp // comparator outputs
);
  timeunit 1ns;
  timeprecision 1ps;
  import uv_pkg::*;
  // two trip points, so the levels never overlap
  always_comb begin
    comp.below_fall = (level == 2'h0);
    comp.above_rise = (level == 2'h2);
  end
endmodule : uv_supply_model
`default_nettype wire

// [verif/undervoltage_reset_filter_tb_top.sv]
`default_nettype none
module undervoltage_reset_filter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import uv_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, wait_mode = 1'b0, stop_mode = 1'b0;
  logic [1:0] level = 2'h2, s_axi_bresp, s_axi_rresp, r;
  comp_t comp;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic uv_reset, ext_reset_n, ext_reset_oe, irq;
  int n_errors = 0, n_compared = 0, cyc = 0;
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  uv_supply_model sup_u (.level, .comp);
  undervoltage_reset_filter dut_u (.aclk, .aresetn, .comp, .wait_mode, .stop_mode, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .uv_reset, .ext_reset_n,
    .ext_reset_oe, .irq);
  ////////////////////////////////////////////////////////////
  task automatic final_report();
    if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  function automatic logic [31:0] stat_exp(input logic f);
    return {24'h0, f, 7'h0};
  endfunction : stat_exp
  // answer is sampled at the falling edge, acted on after the rising one
  task automatic acc(input logic w, input logic [17:0] a, input logic [31:0] wd);
    logic ah, wh, bh;
    if (w) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {14'h0, a, wd, 3'h7};
    else {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {14'h0, a, 2'h3};
    do begin
      @(negedge aclk);
      ah = w ? s_axi_awready : s_axi_arready;
      wh = s_axi_wready;
      bh = w ? s_axi_bvalid : s_axi_rvalid;
      d = s_axi_rdata;
      r = w ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (ah && w) s_axi_awvalid <= 1'b0;
      if (wh && w) s_axi_wvalid <= 1'b0;
      if (ah && !w) s_axi_arvalid <= 1'b0;
    end while (!bh);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    #1;
  endtask : acc
  task automatic rdc(input logic [17:0] a, input logic [31:0] e, input logic [1:0] er);
    acc(1'b0, a, 32'h0);
    cmp(d, e);
    cmp({30'h0, r}, {30'h0, er});
  endtask : rdc
  task automatic wrc(input logic [17:0] a, input logic [31:0] v, input logic [1:0] er);
    acc(1'b1, a, v);
    cmp({30'h0, r}, {30'h0, er});
  endtask : wrc
  task automatic hold(input logic [1:0] l, input int n);
    level <= l;
    repeat (n) @(posedge aclk);
    #1;
  endtask : hold
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h88dc));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    rdc(STATUS_ADDR, 32'h0, RESP_OKAY);
    rdc(CONFIG_ADDR, 32'h1, RESP_OKAY);
    rdc(18'h00020, 32'h0, RESP_SLVERR);
    wrc(18'h00024, 32'h1, RESP_SLVERR);
    hold(2'h0, 100);
    rdc(STATUS_ADDR, stat_exp(1'b0), RESP_OKAY);
    hold(2'h0, 80);
    rdc(STATUS_ADDR, stat_exp(1'b1), RESP_OKAY);
    cmp({31'h0, uv_reset}, 32'h0);
    wrc(STATUS_ADDR, 32'hff, RESP_OKAY);
    rdc(STATUS_ADDR, stat_exp(1'b1), RESP_OKAY);
    hold(2'h1, 5 + $urandom % 40);
    rdc(STATUS_ADDR, stat_exp(1'b1), RESP_OKAY);
    hold(2'h2, 1);
    rdc(STATUS_ADDR, stat_exp(1'b0), RESP_OKAY);
    wrc(CONFIG_ADDR, 32'h3, RESP_OKAY);
    wait_mode <= 1'b1;
    repeat (20) begin
      hold(2'h0, 1 + $urandom % 8);
      hold(2'h1 + 2'($urandom % 2), 1);
    end
    cmp({31'h0, uv_reset}, 32'h0);
    hold(2'h0, 12);
    cmp({31'h0, uv_reset}, 32'h1);
    cmp({31'h0, ext_reset_n}, 32'h0);
    cmp({31'h0, ext_reset_oe}, 32'h1);
    hold(2'h1, 5 + $urandom % 50);
    cmp({31'h0, uv_reset}, 32'h1);
    hold(2'h2, 1);
    hold(2'h1, 2);
    cmp({31'h0, uv_reset}, 32'h0);
    cmp({31'h0, ext_reset_n, ext_reset_oe}, 32'h2);
    wait_mode <= 1'b0;
    acc(1'b1, CONFIG_ADDR, 32'h2);
    hold(2'h0, 200);
    cmp({31'h0, uv_reset}, 32'h0);
    rdc(STATUS_ADDR, stat_exp(1'b0), RESP_OKAY);
    acc(1'b1, CONFIG_ADDR, 32'h3);
    stop_mode <= 1'b1;
    hold(2'h0, 30);
    cmp({31'h0, uv_reset}, 32'h0);
    hold(2'h2, 2);
    acc(1'b1, CONFIG_ADDR, 32'h7);
    hold(2'h0, 3);
    cmp({31'h0, uv_reset}, 32'h1);
    stop_mode <= 1'b0;
    hold(2'h2, 2);
    acc(1'b1, IRQ_MASK_ADDR, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    acc(1'b1, IRQ_MASK_ADDR, 32'h1);
    cmp({31'h0, irq}, 32'h1);
    acc(1'b1, IRQ_STAT_ADDR, 32'h7);
    cmp({31'h0, irq}, 32'h0);
    rdc(IRQ_STAT_ADDR, 32'h0, RESP_OKAY);
    hold(2'h0, 200);
    aresetn <= 1'b0;
    hold(2'h0, 2);
    aresetn <= 1'b1;
    hold(2'h0, 1);
    rdc(STATUS_ADDR, stat_exp(1'b0), RESP_OKAY);
    hold(2'h0, 200);
    rdc(STATUS_ADDR, stat_exp(1'b1), RESP_OKAY);
    final_report();
  end
endmodule : undervoltage_reset_filter_tb_top
bind undervoltage_reset_filter uv_chk chk_u (.aclk, .aresetn, .comp, .stop_mode, .uv_reset, .ext_reset_n,
  .ext_reset_oe, .irq, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire
